// [core/dax_supervisor.sv]
/*
 * Drive auxiliary supervision: current arrival, timed run, analog window,
 * heatsink flags, fan control, sleep/wake and run-time arrival.
 * Assumes synchronous inputs and a simple strobe register port.
 */
`timescale 1ns/10ps
`default_nettype none
module dax_supervisor
    import dax_pkg::*;
#(
    parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    input  wire logic              run_cmd,
    input  wire logic              running,
    input  wire logic [CUR_W-1:0]  output_current,
    input  wire logic [FREQ_W-1:0] set_freq,
    input  wire logic [TEMP_W-1:0] heat_temp,
    input  wire logic [VOLT_W-1:0] analog_voltage_input_one,
    input  wire logic [VOLT_W-1:0] analog_input_two,
    output logic                   stop_req,
    output logic                   asleep,
    output logic                   cur_arrive,
    output logic                   timed_done,
    output logic                   ain_window,
    output logic                   temp_reached,
    output logic                   fan_on,
    output logic                   runtime_arrive,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [3:0]        ctrl, next_ctrl;
    logic [CUR_W-1:0]  lvl [2], next_lvl [2], wid [2], next_wid [2];
    logic [MIN_W-1:0]  timed_dur, next_timed_dur, run_arr, next_run_arr;
    logic [VOLT_W-1:0] lo, next_lo, hi, next_hi;
    logic [TEMP_W-1:0] temp_thr, next_temp_thr;
    logic [FREQ_W-1:0] wake_f, next_wake_f, sleep_f, next_sleep_f;
    logic [SEC_W-1:0]  wake_d, next_wake_d, sleep_d, next_sleep_d;
    logic [N_EVT-1:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;

    function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    // Writes other than control, frequencies and mask are clipped to the documented ranges so the compares stay sane
    always_comb begin
        next_ctrl = ctrl;
        next_lvl = lvl;
        next_wid = wid;
        next_timed_dur = timed_dur;
        next_lo = lo;
        next_hi = hi;
        next_temp_thr = temp_thr;
        next_wake_f = wake_f;
        next_wake_d = wake_d;
        next_sleep_f = sleep_f;
        next_sleep_d = sleep_d;
        next_run_arr = run_arr;
        next_irq_mask = irq_mask;
        if (wr) begin
            case (addr)
                OFS_CTRL:     next_ctrl = wdata[3:0];
                OFS_CUR1, OFS_CUR2: begin
                    next_lvl[addr[3]] = CUR_W'(clip(16'(wdata[CUR_W-1:0]), 16'(CUR_MAX)));
                    next_wid[addr[3]] = CUR_W'(clip(16'(wdata[HI_LSB+:CUR_W]), 16'(CUR_MAX)));
                end
                OFS_TIMED:    next_timed_dur = clip(wdata[15:0], MIN_MAX);
                OFS_AIN_LIM: begin
                    next_hi = VOLT_W'(clip(16'(wdata[HI_LSB+:VOLT_W]), 16'(VOLT_MAX)));
                    next_lo = VOLT_W'(clip(16'(wdata[VOLT_W-1:0]), 16'(next_hi)));
                end
                OFS_TEMP:     next_temp_thr = TEMP_W'(clip(16'(wdata[7:0]), 16'(TEMP_MAX)));
                OFS_WAKE_F:   next_wake_f = wdata[15:0];
                OFS_WAKE_D:   next_wake_d = clip(wdata[15:0], SEC_MAX);
                OFS_SLEEP_F:  next_sleep_f = wdata[15:0];
                OFS_SLEEP_D:  next_sleep_d = clip(wdata[15:0], SEC_MAX);
                OFS_RUN_ARR:  next_run_arr = clip(wdata[15:0], MIN_MAX);
                OFS_IRQ_MASK: next_irq_mask = wdata[N_EVT-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= '0;
            lvl <= '{CUR_LVL_DEF, CUR_LVL_DEF};
            wid <= '{'0, '0};
            timed_dur <= '0;
            lo <= LO_DEF;
            hi <= HI_DEF;
            temp_thr <= TEMP_DEF;
            wake_f <= '0;
            wake_d <= '0;
            sleep_f <= '0;
            sleep_d <= '0;
            run_arr <= '0;
            irq_mask <= '0;
        end else begin
            ctrl <= next_ctrl;
            lvl <= next_lvl;
            wid <= next_wid;
            timed_dur <= next_timed_dur;
            lo <= next_lo;
            hi <= next_hi;
            temp_thr <= next_temp_thr;
            wake_f <= next_wake_f;
            wake_d <= next_wake_d;
            sleep_f <= next_sleep_f;
            sleep_d <= next_sleep_d;
            run_arr <= next_run_arr;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ticks and run timer
    logic             run_q, start, sec_tick, dmin_tick;
    logic [MIN_W-1:0] elapsed, next_elapsed, dur_eff, remain;
    logic [VOLT_W-1:0] ain_sel;
    logic [26:0]      scaled;

    assign start = running && !run_q;

    dax_tick #(.CYC_SEC(CYC_SEC)) u_tick (
        .clk       (clk),
        .rstn      (rstn),
        .restart   (start),
        .sec_tick  (sec_tick),
        .dmin_tick (dmin_tick)
    );

    // Full-scale analog input maps onto the stored duration; 3 acts as stored
    always_comb begin
        ain_sel = (ctrl[CTRL_SRC_LSB+:2] == SRC_AIN1) ? analog_voltage_input_one
                                                       : analog_input_two;
        if (ain_sel > AIN_FULL) ain_sel = AIN_FULL;
        scaled = (27'(ain_sel) * 27'(timed_dur)) / 27'(AIN_FULL);
        case (ctrl[CTRL_SRC_LSB+:2])
            SRC_AIN1, SRC_AIN2: dur_eff = MIN_W'(scaled);
            default:            dur_eff = timed_dur;
        endcase
        remain = (dur_eff > elapsed) ? dur_eff - elapsed : '0;
    end

    // Elapsed run time in 0.1 min, saturating, restarted from zero
    always_comb begin
        next_elapsed = elapsed;
        if (start) next_elapsed = '0;
        else if (running && dmin_tick && elapsed != MIN_MAX)
            next_elapsed = elapsed + MIN_W'(1);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
            elapsed <= '0;
        end else begin
            run_q <= running;
            elapsed <= next_elapsed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep / wake sequencer, counted in whole seconds
    dax_sleep_e       sl_st, next_sl_st;
    logic [SEC_W-1:0] sl_cnt, next_sl_cnt;
    logic             sl_en;

    assign sl_en = (wake_f != '0) || (sleep_f != '0);

    always_comb begin
        next_sl_st = sl_st;
        next_sl_cnt = sl_cnt;
        case (sl_st)
            st_awake: begin
                if (sl_en && running && set_freq <= sleep_f) begin
                    if (sl_cnt >= sleep_d) begin
                        next_sl_st = st_asleep;
                        next_sl_cnt = '0;
                    end else if (sec_tick) next_sl_cnt = sl_cnt + SEC_W'(1);
                end else next_sl_cnt = '0;
            end
            st_asleep: begin
                if (!sl_en || !run_cmd) begin
                    next_sl_st = st_awake;
                    next_sl_cnt = '0;
                end else if (set_freq >= wake_f) begin
                    if (sl_cnt >= wake_d) begin
                        next_sl_st = st_awake;
                        next_sl_cnt = '0;
                    end else if (sec_tick) next_sl_cnt = sl_cnt + SEC_W'(1);
                end else next_sl_cnt = '0;
            end
            default: begin
                next_sl_st = st_awake;
                next_sl_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sl_st <= st_awake;
            sl_cnt <= '0;
        end else begin
            sl_st <= next_sl_st;
            sl_cnt <= next_sl_cnt;
        end
    end

    assign asleep = (sl_st == st_asleep);
    assign stop_req = asleep || timed_done;

    ////////////////////////////////////////////////////////////////////////
    // Output terminal flags, all registered levels
    logic [1:0] hit;
    logic next_cur, next_done, next_ain, next_temp, next_fan, next_rta;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_pt
            // Window test with one extra bit so level + width cannot wrap
            assign hit[i] = ({1'b0, output_current} + {1'b0, wid[i]} >= {1'b0, lvl[i]})
                         && ({1'b0, output_current} <= {1'b0, lvl[i]} + {1'b0, wid[i]});
        end
    endgenerate

    always_comb begin
        next_cur  = |hit;
        next_done = timed_done;
        if (start) next_done = 1'b0;
        else if (ctrl[CTRL_TIMED_EN] && running && elapsed >= dur_eff) next_done = 1'b1;
        next_ain  = (analog_voltage_input_one > hi) || (analog_voltage_input_one < lo);
        next_temp = heat_temp >= temp_thr;
        if (ctrl[CTRL_FAN_MODE]) next_fan = 1'b1;
        else next_fan = running || (heat_temp > FAN_TEMP);
        next_rta  = running && (elapsed >= run_arr);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_arrive <= 1'b0;
            timed_done <= 1'b0;
            ain_window <= 1'b0;
            temp_reached <= 1'b0;
            fan_on <= 1'b0;
            runtime_arrive <= 1'b0;
        end else begin
            cur_arrive <= next_cur;
            timed_done <= next_done;
            ain_window <= next_ain;
            temp_reached <= next_temp;
            fan_on <= next_fan;
            runtime_arrive <= next_rta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: rising flags set sticky bits, write one clears, set wins
    logic [N_EVT-1:0] flags, flags_q, evt;

    assign flags = {asleep, runtime_arrive, fan_on, temp_reached,
                    ain_window, timed_done, cur_arrive};
    assign evt = flags & ~flags_q;

    generate
        for (genvar b = 0; b < N_EVT; b++) begin : g_irq
            assign next_irq_stat[b] = evt[b] ||
                (irq_stat[b] && !(wr && addr == OFS_IRQ_STAT && wdata[b]));
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '0;
            irq_stat <= '0;
        end else begin
            flags_q <= flags;
            irq_stat <= next_irq_stat;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero otherwise
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (rd) begin
            case (addr)
                OFS_CTRL:     next_rdata = 32'(ctrl);
                OFS_CUR1:     next_rdata = {4'h0, wid[0], 4'h0, lvl[0]};
                OFS_CUR2:     next_rdata = {4'h0, wid[1], 4'h0, lvl[1]};
                OFS_TIMED:    next_rdata = 32'(timed_dur);
                OFS_AIN_LIM:  next_rdata = {5'h00, hi, 5'h00, lo};
                OFS_TEMP:     next_rdata = 32'(temp_thr);
                OFS_WAKE_F:   next_rdata = 32'(wake_f);
                OFS_WAKE_D:   next_rdata = 32'(wake_d);
                OFS_SLEEP_F:  next_rdata = 32'(sleep_f);
                OFS_SLEEP_D:  next_rdata = 32'(sleep_d);
                OFS_RUN_ARR:  next_rdata = 32'(run_arr);
                OFS_STATUS:   next_rdata = 32'(flags);
                OFS_REMAIN:   next_rdata = 32'(remain);
                OFS_IRQ_STAT: next_rdata = 32'(irq_stat);
                OFS_IRQ_MASK: next_rdata = 32'(irq_mask);
                default:      next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rdata <= '0;
        else rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_cur;
        (output_current == lvl[0]) |=> cur_arrive;
    endproperty
    a_cur: assert property (p_cur) else $error("current arrival missed");
    property p_timed;
        ctrl[CTRL_TIMED_EN] && running && !start && elapsed >= dur_eff |=> timed_done && stop_req;
    endproperty
    a_timed: assert property (p_timed) else $error("timed run not stopped");
    property p_clear;
        start |=> elapsed == '0 && !timed_done;
    endproperty
    a_clear: assert property (p_clear) else $error("run timer not cleared");
    property p_ain;
        analog_voltage_input_one > hi |=> ain_window;
    endproperty
    a_ain: assert property (p_ain) else $error("analog window missed");
    property p_temp;
        heat_temp >= temp_thr |=> temp_reached;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature flag missed");
    property p_fan0;
        !ctrl[CTRL_FAN_MODE] && !running && heat_temp <= FAN_TEMP |=> !fan_on;
    endproperty
    a_fan0: assert property (p_fan0) else $error("fan on while cool");
    property p_fan1;
        ctrl[CTRL_FAN_MODE] |=> fan_on;
    endproperty
    a_fan1: assert property (p_fan1) else $error("fan off in mode 1");
    property p_sleep;
        !sl_en |=> !asleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep while disabled");
    property p_asleep_stop;
        $rose(asleep) |-> ($past(set_freq) <= $past(sleep_f)) && stop_req;
    endproperty
    a_asleep_stop: assert property (p_asleep_stop) else $error("bad sleep entry");
    property p_rta;
        running && elapsed >= run_arr |=> runtime_arrive;
    endproperty
    a_rta: assert property (p_rta) else $error("run time flag missed");
    property p_tick;
        sec_tick |=> !sec_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick longer than a cycle");

    c_done:  cover property ($rose(timed_done));
    c_sleep: cover property ($rose(asleep));
    c_wake:  cover property ($fell(asleep) && run_cmd);
    c_irq:   cover property ($rose(irq));
endmodule
`default_nettype wire

// [core/dax_pkg.sv]
/*
 * Constants shared by the drive auxiliary supervision block: register
 * offsets, field positions, reset values, limits and timing counts.
 * Assumes a 100 MHz system clock and the unit scaling listed below.
 */
package dax_pkg;
    // Timing: one-second base tick and 0.1 minute tick
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TICK_S       = 1;
    localparam int unsigned CYC_PER_SEC  = CLK_HZ * TICK_S;
    localparam int unsigned SEC_PER_DMIN = 6;

    // Widths: current 0.1 %, volts 0.01 V, degrees, 0.01 Hz, 0.1 min, s
    localparam int unsigned CUR_W  = 12;
    localparam int unsigned VOLT_W = 11;
    localparam int unsigned TEMP_W = 8;
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned MIN_W  = 16;
    localparam int unsigned SEC_W  = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned N_EVT  = 7;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CUR1     = 8'h04;
    localparam logic [7:0] OFS_CUR2     = 8'h08;
    localparam logic [7:0] OFS_TIMED    = 8'h0C;
    localparam logic [7:0] OFS_AIN_LIM  = 8'h10;
    localparam logic [7:0] OFS_TEMP     = 8'h14;
    localparam logic [7:0] OFS_WAKE_F   = 8'h18;
    localparam logic [7:0] OFS_WAKE_D   = 8'h1C;
    localparam logic [7:0] OFS_SLEEP_F  = 8'h20;
    localparam logic [7:0] OFS_SLEEP_D  = 8'h24;
    localparam logic [7:0] OFS_RUN_ARR  = 8'h28;
    localparam logic [7:0] OFS_STATUS   = 8'h2C;
    localparam logic [7:0] OFS_REMAIN   = 8'h30;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h38;

    // Field positions
    localparam int unsigned CTRL_TIMED_EN = 0;
    localparam int unsigned CTRL_SRC_LSB  = 1;
    localparam int unsigned CTRL_FAN_MODE = 3;
    localparam int unsigned HI_LSB        = 16;

    // Duration source codes
    localparam logic [1:0] SRC_STORED = 2'h0;
    localparam logic [1:0] SRC_AIN1   = 2'h1;
    localparam logic [1:0] SRC_AIN2   = 2'h2;

    // Reset values and limits
    localparam logic [CUR_W-1:0]  CUR_LVL_DEF = 12'h3E8;
    localparam logic [CUR_W-1:0]  CUR_MAX     = 12'hBB8;
    localparam logic [VOLT_W-1:0] LO_DEF      = 11'h136;
    localparam logic [VOLT_W-1:0] HI_DEF      = 11'h2A8;
    localparam logic [VOLT_W-1:0] VOLT_MAX    = 11'h44C;
    localparam logic [VOLT_W-1:0] AIN_FULL    = 11'h3E8;
    localparam logic [TEMP_W-1:0] TEMP_DEF    = 8'h4B;
    localparam logic [TEMP_W-1:0] TEMP_MAX    = 8'h64;
    localparam logic [TEMP_W-1:0] FAN_TEMP    = 8'h28;
    localparam logic [MIN_W-1:0]  MIN_MAX     = 16'hFDE8;
    localparam logic [SEC_W-1:0]  SEC_MAX     = 16'hFDE8;

    // Sleep sequencer states
    typedef enum logic [1:0] {
        st_awake  = 2'b01,
        st_asleep = 2'b10
    } dax_sleep_e;
endpackage

// [core/dax_tick.sv]
/*
 * Prescaler giving a one-cycle second tick and a 0.1 minute tick.
 * Assumes restart is a one-cycle pulse from the owning block.
 */
`timescale 1ns/10ps
`default_nettype none
module dax_tick
    import dax_pkg::*;
#(
    parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      sec_tick,
    output logic      dmin_tick
);
    localparam int unsigned CW = $clog2(CYC_SEC + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_SEC - 1);
    localparam logic [3:0]    DMIN_LAST = 4'(SEC_PER_DMIN - 1);

    logic [CW-1:0] cyc;
    logic [CW-1:0] next_cyc;
    logic [3:0]    sec;
    logic [3:0]    next_sec;

    // Restart realigns both ticks so a run counts whole periods from start
    always_comb begin
        next_cyc = cyc + CW'(1);
        next_sec = sec;
        if (restart) begin
            next_cyc = '0;
            next_sec = '0;
        end else if (cyc == CYC_LAST) begin
            next_cyc = '0;
            next_sec = (sec == DMIN_LAST) ? 4'h0 : sec + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc <= '0;
            sec <= '0;
        end else begin
            cyc <= next_cyc;
            sec <= next_sec;
        end
    end

    assign sec_tick  = (cyc == CYC_LAST) && !restart;
    assign dmin_tick = sec_tick && (sec == DMIN_LAST);
endmodule
`default_nettype wire

// [tb/dax_drive_model.sv]
/*
 * Drive run-control model facing the supervision block.
 * Assumes run_cmd and stop_req are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module dax_drive_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic run_cmd,
    input  wire logic stop_req,
    output logic      running
);
    logic cmd_q;
    logic start_q;
    // A fresh command starts the drive; a stale stop request is ignored one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q   <= 1'b0;
            start_q <= 1'b0;
            running <= 1'b0;
        end else begin
            cmd_q   <= run_cmd;
            start_q <= run_cmd && !cmd_q;
            running <= run_cmd && (!cmd_q || start_q || !stop_req);
        end
    end
endmodule
`default_nettype wire

// [tb/tb_drive_aux_supervision.sv]
/*
 * Self-checking bench for the drive auxiliary supervision block.
 * Assumes a shortened second of CS cycles and the drive model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_drive_aux_supervision;
    import dax_pkg::*;
    localparam int CS = 10;
    logic clk, rstn, wr, rd, run_cmd, running, stop_req, asleep, irq;
    logic cur_arrive, timed_done, ain_window, temp_reached, fan_on, runtime_arrive;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata, rdata;
    logic [CUR_W-1:0]  cur;
    logic [FREQ_W-1:0] sfreq;
    logic [TEMP_W-1:0] temp;
    logic [VOLT_W-1:0] ain1, ain2;
    int                num_errors, n_tests, n;
    ////////////////////////////////////////////////////////////////////////
    dax_supervisor #(.CYC_SEC(CS)) dut (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_cmd(run_cmd),
        .running(running), .output_current(cur), .set_freq(sfreq),
        .heat_temp(temp), .analog_voltage_input_one(ain1),
        .analog_input_two(ain2), .stop_req(stop_req), .asleep(asleep),
        .cur_arrive(cur_arrive), .timed_done(timed_done), .ain_window(ain_window),
        .temp_reached(temp_reached), .fan_on(fan_on),
        .runtime_arrive(runtime_arrive), .irq(irq));
    dax_drive_model drv (.clk(clk), .rstn(rstn), .run_cmd(run_cmd),
        .stop_req(stop_req), .running(running));
    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wcyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Bus cycles: one-cycle strobes, read data only in the following cycle
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Bounded wait on timed_done (0) or asleep (1); running out ends the run
    task automatic wait_hi(input int which, output int c);
        c = 0;
        // Look just after each edge, once the registered flags have settled
        while (((which == 0) ? timed_done : asleep) !== 1'b1 && c < 500) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c == 500) begin
            num_errors++;
            final_report;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rreg(OFS_CUR1, 32'h000003E8);
        rreg(OFS_AIN_LIM, {5'h00, HI_DEF, 5'h00, LO_DEF});
        rreg(OFS_TEMP, 32'h0000004B);
        rreg(OFS_TIMED, 32'h00000000);
        rreg(8'hFC, 32'h00000000);
        $display("test regs done");
    endtask
    // Window edges for both arrival points, the second one reprogrammed
    task automatic t_current;
        logic [CUR_W-1:0] v[4] = '{12'h7C6, 12'h7C5, 12'h3E8, 12'h3E9};
        logic             e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wreg(OFS_CUR2, 32'h000A07D0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cur <= v[i];
            wcyc(3);
            chk(cur_arrive, e[i]);
        end
        $display("test current done");
    endtask
    task automatic t_window;
        logic [VOLT_W-1:0] v[4] = '{11'h136, 11'h135, 11'h2A8, 11'h2A9};
        logic              e[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            ain1 <= v[i];
            wcyc(3);
            chk(ain_window, e[i]);
        end
        @(posedge clk);
        ain1 <= 11'h1F4;
        $display("test window done");
    endtask
    // Drive stopped: fan follows the 40 degree limit, then mode 1 forces it on
    task automatic t_thermal;
        logic [TEMP_W-1:0] v[4] = '{8'h28, 8'h29, 8'h4B, 8'h4A};
        logic [1:0]        e[4] = '{2'b00, 2'b01, 2'b11, 2'b01};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            temp <= v[i];
            wcyc(3);
            chk({temp_reached, fan_on}, e[i]);
        end
        @(posedge clk);
        temp <= 8'h14;
        wreg(OFS_CTRL, 32'h00000008);
        wcyc(3);
        chk(fan_on, 1'b1);
        wreg(OFS_CTRL, 32'h00000000);
        $display("test thermal done");
    endtask
    // One timed run: duration d in 0.1 min, each worth 6 seconds of CS cycles
    task automatic t_timed(input logic [1:0] src, input int d);
        int pre;
        pre = (d == 2) ? 65 : 0;
        wreg(OFS_CTRL, {29'h0, src, 1'b1});
        run_cmd <= 1'b1;
        wcyc(1);
        rreg(OFS_REMAIN, d);
        if (d == 2) begin
            wcyc(pre);
            chk({fan_on, runtime_arrive}, 2'b11);
        end
        wait_hi(0, n);
        chk((n + pre + 3) inside {[d * 6 * CS - 4 : d * 6 * CS + 4]}, 1'b1);
        // The sticky bit follows the registered flag by one cycle
        wcyc(1);
        chk({stop_req, irq}, 2'b11);
        wcyc(2);
        chk(running, 1'b0);
        wreg(OFS_IRQ_STAT, 32'h00000002);
        wcyc(1);
        chk(irq, 1'b0);
        @(posedge clk);
        run_cmd <= 1'b0;
        wcyc(2);
        $display("test timed source %0d done", src);
    endtask
    // Sleep and wake with wake frequency kept above sleep frequency
    task automatic t_sleep;
        wreg(OFS_SLEEP_F, 32'h000003E8);
        wreg(OFS_WAKE_F, 32'h000007D0);
        wreg(OFS_SLEEP_D, 32'h00000001);
        sfreq   <= 16'h1388;
        run_cmd <= 1'b1;
        wcyc(3);
        @(posedge clk);
        sfreq <= 16'h0384;
        wait_hi(1, n);
        chk(n inside {[CS - 2 : CS + 4]}, 1'b1);
        wcyc(3);
        chk({stop_req, running}, 2'b10);
        @(posedge clk);
        sfreq <= 16'h07D0;
        wcyc(5);
        chk({asleep, running}, 2'b01);
        wreg(OFS_SLEEP_F, 32'h00000000);
        wreg(OFS_WAKE_F, 32'h00000000);
        sfreq <= 16'h0000;
        wcyc(30);
        chk({asleep, running}, 2'b01);
        @(posedge clk);
        run_cmd <= 1'b0;
        $display("test sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; PID is outside this block, so nothing is set for it
    initial begin
        num_errors = 0;
        n_tests = 0;
        {rstn, wr, rd, run_cmd, addr, wdata} = '0;
        cur   = 12'h000;
        sfreq = 16'h1388;
        temp  = 8'h14;
        ain1  = 11'h1F4;
        ain2  = AIN_FULL;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_current;
        t_window;
        t_thermal;
        wreg(OFS_TIMED, 32'h00000002);
        wreg(OFS_RUN_ARR, 32'h00000001);
        wreg(OFS_IRQ_MASK, 32'h00000002);
        t_timed(SRC_STORED, 2);
        t_timed(SRC_AIN1, 1);
        t_timed(SRC_AIN2, 2);
        t_timed(2'h3, 2);
        t_sleep;
        final_report;
    end
endmodule
`default_nettype wire
